/* File: src/tdf_top.sv */
// triple edge-triggered storage elements with an apb control and status port
// assumes all pins synchronous to clock_i; set and clear act at the
// next clock edge, and a clock edge is seen as a low then high sample
`timescale 1ns/1ps

module tdf_top (
  // clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          resetn_i,
  // storage element pins
  input  wire logic [tdf_pkg::NUM_ELEM-1:0]  data_i,
  input  wire logic [tdf_pkg::NUM_ELEM-1:0]  per_element_clock_i,
  input  wire logic                          shared_clock_i,
  input  wire logic                          global_preset_i,
  input  wire logic                          global_clear_i,
  input  wire logic [tdf_pkg::NUM_ELEM-1:0]  element_preset_i,
  input  wire logic [tdf_pkg::NUM_ELEM-1:0]  element_clear_i,
  output logic      [tdf_pkg::NUM_ELEM-1:0]  stored_bit_out_o,
  output logic      [tdf_pkg::NUM_ELEM-1:0]  stored_bit_out_n_o,
  // apb slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [tdf_pkg::ADDR_W-1:0]    paddr_i,
  input  wire logic [tdf_pkg::DATA_W-1:0]    pwdata_i,
  output logic      [tdf_pkg::DATA_W-1:0]    prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o
);
  import tdf_pkg::*;

  // ****************************************************************
  // helper
  // ****************************************************************
  // rising transition between two samples
  function automatic logic rise_seen(input logic now, input logic prev);
    rise_seen = now & ~prev;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [NUM_ELEM-1:0] q_reg,      q_next;      // slave (output) bits
  logic [NUM_ELEM-1:0] master_reg, master_next; // master bits
  logic [NUM_ELEM-1:0] ck_reg;                  // last per-element clocks
  logic                ckc_reg;                 // last shared clock
  logic [NUM_ELEM-1:0] sset_reg,   sset_next;   // software set
  logic [NUM_ELEM-1:0] sclr_reg,   sclr_next;   // software clear
  logic [DATA_W-1:0]   rdata_reg,  rdata_next;  // read data
  logic                err_reg,    err_next;    // unmapped access
  logic [NUM_ELEM-1:0] set_eff;                 // all set sources
  logic [NUM_ELEM-1:0] clr_eff;                 // all clear sources
  logic [NUM_ELEM-1:0] trig;                    // transfer to slave

  // ****************************************************************
  // storage elements
  // ****************************************************************
  // merge global, per-element and software set/clear
  always_comb begin
    set_eff = element_preset_i | sset_reg
            | {NUM_ELEM{global_preset_i}};
    clr_eff = element_clear_i | sclr_reg
            | {NUM_ELEM{global_clear_i}};
  end

  // per element next master and slave values
  always_comb begin
    for (int n = 0; n < NUM_ELEM; n++) begin
      // either clock rises while the other was low
      trig[n] = (rise_seen(per_element_clock_i[n], ck_reg[n]) & ~ckc_reg)
              | (rise_seen(shared_clock_i, ckc_reg)
                 & ~ck_reg[n]);
      // master transparent only with both clocks low
      if (!per_element_clock_i[n] && !shared_clock_i) begin
        master_next[n] = data_i[n];
      end else begin
        master_next[n] = master_reg[n];
      end
      if (set_eff[n]) begin
        q_next[n] = 1'h1;
      end else if (clr_eff[n]) begin
        q_next[n] = 1'h0;
      end else if (trig[n]) begin
        q_next[n] = master_reg[n];
      end else begin
        q_next[n] = q_reg[n];
      end
    end
  end

  // register the element state and clock samples
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_reg      <= ELEM_RST;
      master_reg <= ELEM_RST;
      ck_reg     <= CLK_RST;
      ckc_reg    <= CLKC_RST;
    end else begin
      q_reg      <= q_next;
      master_reg <= master_next;
      ck_reg     <= per_element_clock_i;
      ckc_reg    <= shared_clock_i;
    end
  end

  // true and complement outputs of one stored bit
  assign stored_bit_out_o   = q_reg;
  assign stored_bit_out_n_o = ~q_reg;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // decode in the setup phase, answer in the access phase
  always_comb begin
    sset_next  = sset_reg;
    sclr_next  = sclr_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (psel_i && !penable_i) begin
      rdata_next = WORD_ZERO;
      err_next   = 1'h0;
      case (paddr_i)
        CTRL_OFS: begin
          rdata_next[SOFT_SET_LSB +: NUM_ELEM] = sset_reg;
          rdata_next[SOFT_CLR_LSB +: NUM_ELEM] = sclr_reg;
        end
        STATUS_OFS: begin
          rdata_next[STAT_Q_LSB +: NUM_ELEM] = q_reg;
          rdata_next[STAT_M_LSB +: NUM_ELEM] = master_reg;
          rdata_next[STAT_CK_LSB +: NUM_ELEM] = ck_reg;
          rdata_next[STAT_CK_LSB + NUM_ELEM] = ckc_reg;
        end
        default: begin
          err_next = 1'h1;                      // unmapped address
        end
      endcase
    end
    // write takes effect at the end of the access phase
    if (psel_i && penable_i && pwrite_i && paddr_i == CTRL_OFS) begin
      sset_next = pwdata_i[SOFT_SET_LSB +: NUM_ELEM];
      sclr_next = pwdata_i[SOFT_CLR_LSB +: NUM_ELEM];
    end
  end

  // register bus state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sset_reg  <= ELEM_RST;
      sclr_reg  <= ELEM_RST;
      rdata_reg <= WORD_ZERO;
      err_reg   <= 1'h0;
    end else begin
      sset_reg  <= sset_next;
      sclr_reg  <= sclr_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  // zero wait states; error only in the access phase, read data driven at all times
  assign pready_o  = 1'h1;
  assign prdata_o  = rdata_reg;
  assign pslverr_o = psel_i & penable_i & err_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  genvar g;
  generate
    for (g = 0; g < NUM_ELEM; g++) begin : g_chk
      compl_out_a: assert property (
        stored_bit_out_n_o[g] == ~stored_bit_out_o[g])
        else $error("complement output wrong");
      master_follow_a: assert property (
        (!per_element_clock_i[g] && !shared_clock_i)
        |=> master_reg[g] == $past(data_i[g]))
        else $error("master did not follow data");
      master_hold_a: assert property (
        (per_element_clock_i[g] || shared_clock_i) |=> $stable(master_reg[g]))
        else $error("master changed with a clock high");
      edge_move_a: assert property (
        (!per_element_clock_i[g] && !shared_clock_i ##1
         (per_element_clock_i[g] || shared_clock_i) &&
         !set_eff[g] && !clr_eff[g])
        |=> stored_bit_out_o[g] == $past(master_reg[g]))
        else $error("clock edge did not move master out");
      preset_win_a: assert property (
        set_eff[g] |=> stored_bit_out_o[g])
        else $error("set did not drive output high");
      clear_win_a: assert property (
        clr_eff[g] && !set_eff[g] |=> !stored_bit_out_o[g])
        else $error("clear did not drive output low");
      no_edge_hold_a: assert property (
        !trig[g] && !set_eff[g] && !clr_eff[g] |=> $stable(q_reg[g]))
        else $error("output changed without an edge");
    end
  endgenerate

  shared_clear_a: assert property (
    global_clear_i && !global_preset_i && element_preset_i == ELEM_RST &&
    sset_reg == ELEM_RST |=> q_reg == ELEM_RST)
    else $error("global clear missed an element");
  both_set_clr_a: assert property (
    global_preset_i && global_clear_i |=> &q_reg)
    else $error("set with clear not resolved high");

  own_clock_c: cover property (
    !per_element_clock_i[0] && !shared_clock_i ##1 per_element_clock_i[0]);
  shared_clock_c: cover property (
    !ck_reg[1] && !ckc_reg && shared_clock_i && !per_element_clock_i[1]);
  preset_c: cover property (global_preset_i ##1 &q_reg);
  bus_write_c: cover property (psel_i && penable_i && pwrite_i);
endmodule

/* File: src/tdf_pkg.sv */
// constants shared by the triple storage element block
// assumes one 25 MHz clock and an apb master with 32-bit data
package tdf_pkg;
  // ****************************************************************
  // structure
  // ****************************************************************
  localparam int NUM_ELEM = 3;                  // storage elements
  localparam int ADDR_W   = 12;                 // apb address width
  localparam int DATA_W   = 32;                 // apb data width
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] CTRL_OFS   = 12'h000; // software set/clear
  localparam logic [11:0] STATUS_OFS = 12'h004; // outputs and masters
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SOFT_SET_LSB = 0;              // ctrl: set per element
  localparam int SOFT_CLR_LSB = 8;              // ctrl: clear per element
  localparam int STAT_Q_LSB   = 0;              // status: stored bits
  localparam int STAT_M_LSB   = 8;              // status: master bits
  localparam int STAT_CK_LSB  = 16;             // status: clock levels
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0]  ELEM_RST  = 3'h0;     // stored and master bits
  localparam logic [2:0]  CLK_RST   = 3'h7;     // clocks seen high
  localparam logic        CLKC_RST  = 1'h1;     // shared clock seen high
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
endpackage

/* File: testbench/tdf_pin_model.sv */
// pin driver standing for the logic around the storage elements
// assumes bench requests in the packed order below; applied one edge on
`timescale 1ns/1ps

module tdf_pin_model (
  // clock and requests
  input  wire logic        clock_i,
  input  wire logic [14:0] req_i,   // {ep,ec,gp,gc,sc,ck,d}
  // pins towards the block
  output logic      [14:0] pins_o
);
  // pins idle low until the first edge
  logic [14:0] pins_q = 15'h0000;

  assign pins_o = pins_q;

  // register requests; an element clear is masked by a set on its element or by the global set, the global clear by any set
  always @(posedge clock_i) begin
    pins_q[6:0]   <= req_i[6:0];
    pins_q[8]     <= req_i[8];
    pins_q[14:12] <= req_i[14:12];
    pins_q[7]     <= req_i[7] & ~req_i[8] & ~|req_i[14:12];
    pins_q[11:9]  <= req_i[11:9] & ~req_i[14:12]
                   & ~{3{req_i[8]}};
  end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the triple storage element block
// assumes tdf_pkg; pins come through tdf_pin_model, registers over apb
`timescale 1ns/1ps

module testbench;
  import tdf_pkg::*;
  logic                clock_i  = 1'h0;
  logic                resetn_i = 1'h0;
  logic [14:0]         req      = 15'h0000; // requests to the pin model
  logic [14:0]         pins;
  logic                psel     = 1'h0;
  logic                penable  = 1'h0;
  logic                pwrite   = 1'h0;
  logic [ADDR_W-1:0]   paddr    = 12'h000;
  logic [DATA_W-1:0]   pwdata   = 32'h00000000;
  logic [DATA_W-1:0]   prdata, rd;
  logic                pready, pslverr, err;
  logic [NUM_ELEM-1:0] q, qn;
  int                  n_errors = 0;
  int                  compares = 0;
  int                  cycles   = 0;

  tdf_pin_model pin_u (.clock_i(clock_i), .req_i(req), .pins_o(pins));
  tdf_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i),
    .data_i(pins[2:0]), .per_element_clock_i(pins[5:3]),
    .shared_clock_i(pins[6]), .global_clear_i(pins[7]),
    .global_preset_i(pins[8]), .element_clear_i(pins[11:9]),
    .element_preset_i(pins[14:12]), .stored_bit_out_o(q),
    .stored_bit_out_n_o(qn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  // 40 ns clock and a cycle ceiling against hangs
  initial forever #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // true and complement outputs together
  task automatic chkq(input logic [2:0] e);
    check("stored", {29'h0, q}, {29'h0, e});
    check("stored_n", {29'h0, qn}, {29'h0, ~e});
  endtask

  // request {ep,ec,gp,gc,sc,ck,d}, let it reach the block and settle
  task automatic drive(input logic [14:0] r);
    @(posedge clock_i);
    req <= r;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  // one apb transfer; data and error taken at the edge pready is high,
  // released only after it; the cycle ceiling ends a hung wait
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'h1;
    do begin
      @(posedge clock_i);
    end while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic t_clock;
    drive(15'h0005);
    drive(15'h003D);
    chkq(3'h5);
    drive(15'h003A);
    chkq(3'h5);
    drive(15'h0002);
    chkq(3'h5);
    drive(15'h0042);
    chkq(3'h2);
    drive(15'h007D);
    chkq(3'h2);
    drive(15'h0005);
    drive(15'h000D);
    chkq(3'h3);
    $display("done pin clocking");
  endtask

  task automatic t_setclr;
    drive(15'h0140);
    chkq(3'h7);
    drive(15'h0440);
    chkq(3'h5);
    drive(15'h00C0);
    chkq(3'h0);
    drive(15'h4040);
    chkq(3'h4);
    drive(15'h0040);
    chkq(3'h4);
    $display("done set and clear");
  endtask

  task automatic t_apb;
    drive(15'h0000);
    apb(1'h1, CTRL_OFS, 32'h00000201);
    repeat (3) @(posedge clock_i);
    apb(1'h0, STATUS_OFS, 32'h00000000);
    check("status", rd & 32'h000F0007, 32'h00000005);
    apb(1'h0, CTRL_OFS, 32'h00000000);
    check("ctrl", rd, 32'h00000201);
    apb(1'h1, CTRL_OFS, 32'h00000000);
    apb(1'h0, 12'h008, 32'h00000000);
    check("unmapped_err", {31'h0, err}, 32'h00000001);
    check("unmapped_data", rd, 32'h00000000);
    $display("done register port");
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'h1;
    @(negedge clock_i);
    chkq(3'h0);
    t_clock();
    t_setclr();
    t_apb();
    results();
  end
endmodule
